// ### hdl/scp_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module scp_ctrl
  import scp_pkg::*;
(
  input  wire logic        pclk,       // Bus clock, 50 MHz
  input  wire logic        presetn,    // Async reset, active low
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB access phase
  input  wire logic        pwrite,     // APB direction
  input  wire logic [31:0] paddr,      // APB byte address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic      [31:0] prdata,     // APB read data
  output logic             pready,     // APB ready
  output logic             pslverr,    // APB error, unmapped address
  input  wire logic        sclk_i,     // Serial clock pin in
  output logic             sclk_o,     // Serial clock pin out
  output logic             sclk_oe,    // Serial clock drive enable
  input  wire logic        mosi_i,     // Controller-out line in
  output logic             mosi_o,     // Controller-out line out
  output logic             mosi_oe,    // Controller-out drive enable
  input  wire logic        miso_i,     // Controller-in line in
  output logic             miso_o,     // Controller-in line out
  output logic             miso_oe,    // Controller-in drive enable
  input  wire logic        ssel_n_i,   // Select pin in, active low
  output logic             ssel_n_o,   // Select pin out, active low
  output logic             ssel_n_oe   // Select drive enable
);

  // Control and state registers
  logic [3:0]            fss_q;
  logic [7:0]            div_q;
  logic                  loopback_select_q;
  logic                  port_enable_q;
  logic                  master_slave_select_q;
  logic                  slave_output_disable_q;
  scp_state_t            state_q;
  logic [7:0]            cnt_q;
  logic [3:0]            bit_q;
  logic [SCP_DATA_W-1:0] sh_q;
  logic [SCP_DATA_W-1:0] rx_q;
  logic                  rx_push_q;
  logic [SCP_DATA_W-1:0] rx_word_q;
  logic                  rd_ok_q;
  logic                  sclk_d_q;

  // Bus decode
  logic                  acc;
  logic                  cap;
  logic                  done;
  logic                  hit;
  logic                  wr_ctrl0;
  logic                  wr_ctrl1;
  logic                  wr_data;
  logic                  rx_pop;

  // Queue and pin views
  logic                  tx_ready;
  logic                  tx_valid;
  logic [SCP_DATA_W-1:0] tx_head;
  logic                  tx_pop;
  logic                  rx_valid;
  logic [SCP_DATA_W-1:0] rx_head;
  logic                  rx_full;
  logic                  sclk_s;
  logic                  mosi_s;
  logic                  miso_s;
  logic                  ssel_n_s;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  ser_in;
  logic [3:0]            top;
  logic                  busy;
  logic                  start_m;
  logic                  start_s;
  logic                  slv_sel;

  // One wait state so that read data comes from a flip-flop
  assign acc      = psel & penable;
  assign cap      = acc & ~pready;
  assign done     = acc & pready;
  assign hit      = (paddr == SCP_CTRL0_ADDR) | (paddr == SCP_CTRL1_ADDR) |
                    (paddr == SCP_DATA_ADDR)  | (paddr == SCP_STAT_ADDR);
  assign wr_ctrl0 = done & pwrite & (paddr == SCP_CTRL0_ADDR);
  assign wr_ctrl1 = done & pwrite & (paddr == SCP_CTRL1_ADDR);
  assign wr_data  = done & pwrite & (paddr == SCP_DATA_ADDR);
  assign rx_pop   = done & ~pwrite & (paddr == SCP_DATA_ADDR) & rd_ok_q;

  // Frame length, unsupported small codes clamp to the shortest frame
  assign top  = (fss_q < SCP_FSS_MIN) ? SCP_FSS_MIN : fss_q;
  assign busy = (state_q != SCP_ST_IDLE) | tx_valid;

  // Edges of the synchronised serial clock
  assign sclk_rise = sclk_s & ~sclk_d_q;
  assign sclk_fall = ~sclk_s & sclk_d_q;
  assign slv_sel   = ~ssel_n_s;

  // Loopback takes the line this end drives in the current mode
  always_comb
  begin
    if (loopback_select_q)
      ser_in = master_slave_select_q ? miso_o : mosi_o;
    else
      ser_in = master_slave_select_q ? mosi_s : miso_s;
  end

  // Frame starts; the queue head is taken on the start cycle
  assign start_m = (state_q == SCP_ST_IDLE) & port_enable_q &
                   ~master_slave_select_q & tx_valid;
  assign start_s = (state_q == SCP_ST_IDLE) & port_enable_q &
                   master_slave_select_q & slv_sel;
  assign tx_pop  = start_m | (start_s & tx_valid);

  scp_sync #(
    .W (4)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({sclk_i, mosi_i, miso_i, ssel_n_i}),
    .q     ({sclk_s, mosi_s, miso_s, ssel_n_s})
  );

  scp_fifo u_tx_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (wr_data),
    .in_data   (pwdata[SCP_DATA_W-1:0]),
    .in_ready  (tx_ready),
    .out_valid (tx_valid),
    .out_data  (tx_head),
    .out_ready (tx_pop),
    .full      ()
  );

  scp_fifo u_rx_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (rx_push_q),
    .in_data   (rx_word_q),
    .in_ready  (),
    .out_valid (rx_valid),
    .out_data  (rx_head),
    .out_ready (rx_pop),
    .full      (rx_full)
  );

  // APB handshake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= cap;
  end

  // Read data and error are captured in the wait cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      rd_ok_q <= 1'b0;
    end
    else if (cap)
    begin
      pslverr <= ~hit;
      rd_ok_q <= rx_valid;
      prdata  <= 32'h0000_0000;
      case (paddr)
        SCP_CTRL0_ADDR:
        begin
          prdata[SCP_FSS_LSB +: 4] <= fss_q;
          prdata[SCP_DIV_LSB +: 8] <= div_q;
        end
        SCP_CTRL1_ADDR:
        begin
          prdata[SCP_LB_BIT]  <= loopback_select_q;
          prdata[SCP_EN_BIT]  <= port_enable_q;
          prdata[SCP_MS_BIT]  <= master_slave_select_q;
          prdata[SCP_SOD_BIT] <= slave_output_disable_q;
        end
        SCP_DATA_ADDR:
          prdata[SCP_DATA_W-1:0] <= rx_head;
        SCP_STAT_ADDR:
        begin
          prdata[SCP_TFE_BIT] <= ~tx_valid;
          prdata[SCP_TNF_BIT] <= tx_ready;
          prdata[SCP_RNE_BIT] <= rx_valid;
          prdata[SCP_RFF_BIT] <= rx_full;
          prdata[SCP_BSY_BIT] <= busy;
        end
        default:
          prdata <= 32'h0000_0000;
      endcase
    end
    else if (done)
      pslverr <= 1'b0;
  end

  // First control word: frame size and bit clock divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fss_q <= SCP_FSS_RST;
      div_q <= SCP_DIV_RST;
    end
    else if (wr_ctrl0)
    begin
      fss_q <= pwdata[SCP_FSS_LSB +: 4];
      div_q <= pwdata[SCP_DIV_LSB +: 8];
    end
  end

  // Second control word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loopback_select_q      <= SCP_CTRL1_RST[SCP_LB_BIT];
      port_enable_q          <= SCP_CTRL1_RST[SCP_EN_BIT];
      master_slave_select_q  <= SCP_CTRL1_RST[SCP_MS_BIT];
      slave_output_disable_q <= SCP_CTRL1_RST[SCP_SOD_BIT];
    end
    else if (wr_ctrl1)
    begin
      loopback_select_q      <= pwdata[SCP_LB_BIT];
      port_enable_q          <= pwdata[SCP_EN_BIT];
      slave_output_disable_q <= pwdata[SCP_SOD_BIT];
      // Mode is judged against the enable as it stood before
      if (!port_enable_q)
        master_slave_select_q <= pwdata[SCP_MS_BIT];
    end
  end

  // Edge history of the synchronised serial clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sclk_d_q <= 1'b0;
    else
      sclk_d_q <= sclk_s;
  end

  // Pin drive enables, everything released while disabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_oe   <= 1'b0;
      mosi_oe   <= 1'b0;
      ssel_n_oe <= 1'b0;
      miso_oe   <= 1'b0;
    end
    else
    begin
      sclk_oe   <= port_enable_q & ~master_slave_select_q;
      mosi_oe   <= port_enable_q & ~master_slave_select_q;
      ssel_n_oe <= port_enable_q & ~master_slave_select_q;
      miso_oe   <= port_enable_q & master_slave_select_q &
                   ~slave_output_disable_q & slv_sel;
    end
  end

  // Shift engine; CPOL 0, CPHA 0, most significant bit first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q   <= SCP_ST_IDLE;
      cnt_q     <= 8'h00;
      bit_q     <= 4'h0;
      sh_q      <= SCP_DATA_RST;
      rx_q      <= SCP_DATA_RST;
      rx_push_q <= 1'b0;
      rx_word_q <= SCP_DATA_RST;
      sclk_o    <= 1'b0;
      mosi_o    <= 1'b0;
      miso_o    <= 1'b0;
      ssel_n_o  <= 1'b1;
    end
    else
    begin
      rx_push_q <= 1'b0;
      cnt_q     <= cnt_q + 8'h01;
      if (!port_enable_q)
      begin
        // Disabling aborts any frame and parks the lines
        state_q  <= SCP_ST_IDLE;
        sclk_o   <= 1'b0;
        ssel_n_o <= 1'b1;
      end
      else
      begin
        case (state_q)
          SCP_ST_IDLE:
          begin
            cnt_q <= 8'h00;
            bit_q <= top;
            rx_q  <= SCP_DATA_RST;
            if (start_m)
            begin
              sh_q     <= tx_head;
              mosi_o   <= tx_head[top];
              ssel_n_o <= 1'b0;
              state_q  <= SCP_ST_MLOW;
            end
            else if (start_s)
            begin
              // Empty queue on select sends zeros
              sh_q    <= tx_valid ? tx_head : SCP_DATA_RST;
              miso_o  <= tx_valid & tx_head[top];
              state_q <= SCP_ST_SSHIFT;
            end
          end
          SCP_ST_MLOW:
            if (cnt_q == div_q)
            begin
              cnt_q   <= 8'h00;
              sclk_o  <= 1'b1;
              rx_q    <= {rx_q[SCP_DATA_W-2:0], ser_in};
              state_q <= SCP_ST_MHIGH;
            end
          SCP_ST_MHIGH:
            if (cnt_q == div_q)
            begin
              cnt_q  <= 8'h00;
              sclk_o <= 1'b0;
              if (bit_q == 4'h0)
              begin
                rx_push_q <= 1'b1;
                rx_word_q <= rx_q;
                state_q   <= SCP_ST_MEND;
              end
              else
              begin
                bit_q   <= bit_q - 4'h1;
                mosi_o  <= sh_q[bit_q - 4'h1];
                state_q <= SCP_ST_MLOW;
              end
            end
          SCP_ST_MEND:
            // Hold select for one half bit after the last edge
            if (cnt_q == div_q)
            begin
              ssel_n_o <= 1'b1;
              state_q  <= SCP_ST_IDLE;
            end
          SCP_ST_SSHIFT:
            if (!slv_sel)
              state_q <= SCP_ST_IDLE;
            else if (sclk_rise)
            begin
              rx_q <= {rx_q[SCP_DATA_W-2:0], ser_in};
              if (bit_q == 4'h0)
              begin
                rx_push_q <= 1'b1;
                rx_word_q <= {rx_q[SCP_DATA_W-2:0], ser_in};
                state_q   <= SCP_ST_SDONE;
              end
            end
            else if (sclk_fall && bit_q != 4'h0)
            begin
              bit_q  <= bit_q - 4'h1;
              miso_o <= sh_q[bit_q - 4'h1];
            end
          SCP_ST_SDONE:
            // One frame per select; wait for its release
            if (!slv_sel)
              state_q <= SCP_ST_IDLE;
          default:
            state_q <= SCP_ST_IDLE;
        endcase
      end
    end
  end

endmodule : scp_ctrl
`default_nettype wire

// ### hdl/scp_pkg.sv
// Overview of operation
// - Loopback routes own serial output into input
// - Enable bit clear keeps port off bus
// - Master/slave bit writable only while disabled
// - Master drives clock, data out, select
// - Slave drives only its data output line
// - Slave output disable stops data output drive
// - Idle master starts newly written word immediately
// - Busy port queues words in written order
// - Data read pops oldest received frame
// - Short received frames read right-aligned, zero-filled
// - Size field n gives n+1 bits; codes below 3 give 4 bits
// - Not-full flag low only when full
// - Not-empty flag low only when empty
// - Busy while shifting or transmit queue nonempty
package scp_pkg;

  // Register byte addresses
  localparam logic [31:0] SCP_CTRL0_ADDR = 32'h4004_0000;
  localparam logic [31:0] SCP_CTRL1_ADDR = 32'h4004_0004;
  localparam logic [31:0] SCP_DATA_ADDR  = 32'h4004_0008;
  localparam logic [31:0] SCP_STAT_ADDR  = 32'h4004_000C;

  // First control word fields
  localparam int          SCP_FSS_LSB    = 0;
  localparam int          SCP_DIV_LSB    = 8;
  localparam logic [3:0]  SCP_FSS_RST    = 4'h0;
  localparam logic [7:0]  SCP_DIV_RST    = 8'h03;
  localparam logic [3:0]  SCP_FSS_MIN    = 4'h3;

  // Second control word bits
  localparam int          SCP_LB_BIT     = 0;
  localparam int          SCP_EN_BIT     = 1;
  localparam int          SCP_MS_BIT     = 2;
  localparam int          SCP_SOD_BIT    = 3;
  localparam logic [3:0]  SCP_CTRL1_RST  = 4'h0;

  // Status word bits
  localparam int          SCP_TFE_BIT    = 0;
  localparam int          SCP_TNF_BIT    = 1;
  localparam int          SCP_RNE_BIT    = 2;
  localparam int          SCP_RFF_BIT    = 3;
  localparam int          SCP_BSY_BIT    = 4;

  // Queue shape
  localparam int          SCP_DATA_W     = 16;
  localparam int          SCP_FIFO_AW    = 3;
  localparam int          SCP_FIFO_DEPTH = 8;
  localparam logic [15:0] SCP_DATA_RST   = 16'h0000;

  // Shift engine states
  typedef enum logic [2:0] {
    SCP_ST_IDLE   = 3'b000,
    SCP_ST_MLOW   = 3'b001,
    SCP_ST_MHIGH  = 3'b010,
    SCP_ST_MEND   = 3'b011,
    SCP_ST_SSHIFT = 3'b100,
    SCP_ST_SDONE  = 3'b101
  } scp_state_t;

endpackage : scp_pkg

// ### hdl/scp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module scp_sync
  import scp_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,     // Sampling clock
  input  wire logic         rst_n,   // Async reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous inputs
  output logic      [W-1:0] q        // Synchronised outputs
);

  logic [W-1:0] meta_q;

  // Two stages; only the second stage reads the first
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : scp_sync
`default_nettype wire

// ### hdl/scp_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module scp_fifo
  import scp_pkg::*;
(
  input  wire logic                  clk,        // Clock
  input  wire logic                  rst_n,      // Async reset, active low
  input  wire logic                  in_valid,   // Push request
  input  wire logic [SCP_DATA_W-1:0] in_data,    // Push data
  output logic                       in_ready,   // Room for a word
  output logic                       out_valid,  // Head word present
  output logic      [SCP_DATA_W-1:0] out_data,   // Head word
  input  wire logic                  out_ready,  // Pop request
  output logic                       full        // No room left
);

  logic [SCP_DATA_W-1:0] mem_q [SCP_FIFO_DEPTH];
  logic [SCP_FIFO_AW:0]  wp_q;
  logic [SCP_FIFO_AW:0]  rp_q;
  logic                  push;
  logic                  pop;

  // Extra pointer bit tells full from empty
  assign full      = (wp_q[SCP_FIFO_AW] != rp_q[SCP_FIFO_AW]) &&
                     (wp_q[SCP_FIFO_AW-1:0] == rp_q[SCP_FIFO_AW-1:0]);
  assign out_valid = (wp_q != rp_q);
  assign in_ready  = ~full;
  assign out_data  = mem_q[rp_q[SCP_FIFO_AW-1:0]];
  assign push      = in_valid & ~full;
  assign pop       = out_ready & out_valid;

  // Pointers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
    end
  end

  // Storage, no reset needed on data
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wp_q[SCP_FIFO_AW-1:0]] <= in_data;
  end

endmodule : scp_fifo
`default_nettype wire

// ### test/scp_checker.sv
`timescale 1ns/10ps
`default_nettype none
module scp_checker
  import scp_pkg::*;
(
  input wire logic        pclk,       // Clock
  input wire logic        presetn,    // Reset, active low
  input wire logic        psel,       // Select
  input wire logic        penable,    // Access phase
  input wire logic        pwrite,     // Direction
  input wire logic [31:0] paddr,      // Address
  input wire logic [31:0] pwdata,     // Write data
  input wire logic [31:0] prdata,     // Read data
  input wire logic        pready,     // Ready
  input wire logic        pslverr,    // Error
  input wire logic        sclk_o,     // Clock out
  input wire logic        sclk_oe,    // Clock enable
  input wire logic        mosi_oe,    // Data out enable
  input wire logic        miso_oe,    // Reply enable
  input wire logic        ssel_n_o,   // Select out
  input wire logic        ssel_n_oe   // Select enable
);
  logic [3:0] sh_q;   // Mirror of second control word
  logic [3:0] st_q;   // Mirror one cycle back
  logic [3:0] fss_q;  // Mirror of frame size
  logic [4:0] cnt_q;  // Clock rises this frame
  logic       sck_q;  // Clock one cycle back
  logic       wr;
  logic       gd;
  logic [4:0] want;

  // Pin enables are registered, so judge only a settled mode
  assign wr   = psel && penable && pready && pwrite && !pslverr;
  assign gd   = sh_q == st_q;
  assign want = (fss_q < SCP_FSS_MIN) ? 5'h04 : {1'b0, fss_q} + 5'h01;

  // Mirror writes; mode bit frozen while enabled
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sh_q  <= 4'h0;
      fss_q <= 4'h0;
    end
    else if (wr && paddr == SCP_CTRL1_ADDR)
    begin
      sh_q[1:0] <= pwdata[1:0];
      sh_q[3]   <= pwdata[3];
      if (!sh_q[1])
        sh_q[2] <= pwdata[2];
    end
    else if (wr && paddr == SCP_CTRL0_ADDR)
      fss_q <= pwdata[3:0];

  // Delay line and clock rise counter
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      st_q  <= 4'h0;
      sck_q <= 1'b0;
      cnt_q <= 5'h00;
    end
    else
    begin
      st_q  <= sh_q;
      sck_q <= sclk_o;
      if (ssel_n_o)
        cnt_q <= 5'h00;
      else if (sclk_o && !sck_q)
        cnt_q <= cnt_q + 5'h01;
    end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_apb_wait:
    assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("Ready not one cycle after access start");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("Ready held too long");
  chk_ctrl_read:
    assert property (pready && !pwrite && paddr == SCP_CTRL1_ADDR
      |-> prdata[3:0] == sh_q) else $error("Control word readback wrong");
  chk_master_oe:
    assert property (gd && sh_q[2:1] == 2'b01
      |-> sclk_oe && mosi_oe && ssel_n_oe && !miso_oe)
    else $error("Master drive set wrong");
  chk_slave_oe:
    assert property (gd && sh_q[2:1] == 2'b11
      |-> !sclk_oe && !mosi_oe && !ssel_n_oe)
    else $error("Slave drives master lines");
  chk_sod_quiet:
    assert property (gd && sh_q[3:1] == 3'b111 |-> !miso_oe)
    else $error("Reply line driven while disabled");
  chk_off_quiet:
    assert property (gd && !sh_q[1]
      |-> !(sclk_oe || mosi_oe || miso_oe || ssel_n_oe))
    else $error("Pins driven while port off");
  chk_frame_bits:
    assert property ($rose(ssel_n_o) && ssel_n_oe |-> cnt_q == want)
    else $error("Wrong bit count in frame");
endmodule : scp_checker

bind scp_ctrl scp_checker chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_oe(mosi_oe),
  .miso_oe(miso_oe), .ssel_n_o(ssel_n_o), .ssel_n_oe(ssel_n_oe));
`default_nettype wire

// ### test/scp_peer.sv
`timescale 1ns/10ps
`default_nettype none
module scp_peer
  import scp_pkg::*;
(
  input  wire logic sclk,      // Resolved clock
  input  wire logic mosi,      // Resolved data out line
  input  wire logic miso,      // Resolved reply line
  input  wire logic ssel_n,    // Resolved select, active low
  output var logic  miso_o,    // Reply bit as slave
  output var logic  miso_oe,   // Reply enable
  output var logic  m_sclk,    // Clock as master
  output var logic  m_mosi,    // Data as master
  output var logic  m_ssel_n,  // Select as master, active low
  output var logic  m_oe       // Master lines enable
);
  logic [7:0] rsp[$];  // Replies to send as slave
  logic [7:0] got[$];  // Words taken as slave
  logic [7:0] tx_q, rx_q, mrx;

  initial
  begin
    miso_o   = 1'b0;
    miso_oe  = 1'b0;
    m_sclk   = 1'b0;
    m_mosi   = 1'b0;
    m_ssel_n = 1'b1;
    m_oe     = 1'b0;
  end

  // Slave role: mode 0, first bit ready before the first rise
  always @(negedge ssel_n)
    if (!m_oe)
    begin
      tx_q    = (rsp.size() > 0) ? rsp.pop_front() : 8'h00;
      miso_oe = 1'b1;
      miso_o  = tx_q[7];
    end
  always @(posedge sclk)
    if (!ssel_n && !m_oe)
      rx_q = {rx_q[6:0], mosi};
  always @(negedge sclk)
    if (!ssel_n && !m_oe)
    begin
      tx_q   = {tx_q[6:0], 1'b0};
      miso_o = tx_q[7];
    end
  always @(posedge ssel_n)
    if (!m_oe && miso_oe)
    begin
      got.push_back(rx_q);
      miso_oe = 1'b0;
    end

  // Master role: one 8-bit frame, clock still outside it
  task automatic xfer(input logic [7:0] w);
    m_oe     = 1'b1;
    m_ssel_n = 1'b0;
    #160;
    for (int i = 7; i >= 0; i--)
    begin
      m_mosi = w[i];
      #80 m_sclk = 1'b1;
      mrx = {mrx[6:0], miso};
      #80 m_sclk = 1'b0;
    end
    #160 m_ssel_n = 1'b1;
    m_oe = 1'b0;
  endtask : xfer
endmodule : scp_peer
`default_nettype wire

// ### test/scp_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
module scp_ctrl_bench;
  import scp_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, tog = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdat;
  logic [31:0] seed = 32'hAD4D;
  logic        pready, pslverr, rerr, sclk_o, sclk_oe, mosi_o, mosi_oe;
  logic        miso_o, miso_oe, ssel_n_o, ssel_n_oe;
  logic        m_sclk, m_mosi, m_miso, m_miso_oe, m_ssel_n, m_oe;
  wire         sclk_w, mosi_w, miso_w, ssel_n_w;
  logic [7:0]  w[SCP_FIFO_DEPTH+2], r[SCP_FIFO_DEPTH+2];
  int          n_fail = 0, n_tests = 0;

  always #10 pclk = ~pclk;
  always @(posedge pclk) tog <= ~tog;

  // Undriven lines wander; select has a pull-up
  assign sclk_w   = sclk_oe ? sclk_o : m_oe ? m_sclk : tog;
  assign mosi_w   = mosi_oe ? mosi_o : m_oe ? m_mosi : ~tog;
  assign miso_w   = miso_oe ? miso_o : m_miso_oe ? m_miso : tog;
  assign ssel_n_w = ssel_n_oe ? ssel_n_o : m_oe ? m_ssel_n : 1'b1;

  scp_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(mosi_w),
    .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe(miso_oe), .ssel_n_i(ssel_n_w), .ssel_n_o(ssel_n_o),
    .ssel_n_oe(ssel_n_oe));
  scp_peer peer_u (.sclk(sclk_w), .mosi(mosi_w), .miso(miso_w),
    .ssel_n(ssel_n_w), .miso_o(m_miso), .miso_oe(m_miso_oe),
    .m_sclk(m_sclk), .m_mosi(m_mosi), .m_ssel_n(m_ssel_n), .m_oe(m_oe));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic report_and_stop;
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One transfer; the request stands until ready is sampled
  task automatic apb(input logic wr, input logic [31:0] a, d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_fail++;
      report_and_stop();
    end
  endtask : apb

  // Poll one status bit under a bound
  task automatic wait_stat(input int b, input logic v);
    int k;
    k = 0;
    do
    begin
      apb(1'b0, SCP_STAT_ADDR, 32'h0);
      k++;
    end
    while (rdat[b] !== v && k < 400);
    if (rdat[b] !== v)
    begin
      n_fail++;
      report_and_stop();
    end
  endtask : wait_stat

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, SCP_CTRL1_ADDR, 32'h0);
    check("ctrl1 reset", rdat[3:0], 4'h0);
    apb(1'b0, SCP_STAT_ADDR, 32'h0);
    check("status reset", rdat[4:0], 5'h03);
    apb(1'b0, 32'h4004_0020, 32'h0);
    check("unmapped", rerr, 1'b1);
    apb(1'b1, SCP_CTRL0_ADDR, 32'h0307);
    apb(1'b1, SCP_CTRL1_ADDR, 32'h2);
    apb(1'b1, SCP_CTRL1_ADDR, 32'h6);
    apb(1'b0, SCP_CTRL1_ADDR, 32'h0);
    check("mode locked", rdat[3:0], 4'h2);
    // Overfill: one word leaves at once, a full queue waits, last dropped
    for (int i = 0; i < SCP_FIFO_DEPTH + 2; i++)
    begin
      seed = lfsr(seed);
      w[i] = seed[7:0];
      r[i] = seed[15:8];
      peer_u.rsp.push_back(r[i]);
    end
    for (int i = 0; i < SCP_FIFO_DEPTH + 2; i++)
      apb(1'b1, SCP_DATA_ADDR, {24'h0, w[i]});
    apb(1'b0, SCP_STAT_ADDR, 32'h0);
    check("tx full busy", rdat[4:0] & 5'h12, 5'h10);
    wait_stat(SCP_BSY_BIT, 1'b0);
    check("rx not empty", rdat[SCP_RNE_BIT], 1'b1);
    check("frames out", peer_u.got.size(), SCP_FIFO_DEPTH + 1);
    for (int i = 0; i <= SCP_FIFO_DEPTH; i++)
      check("sent word", peer_u.got[i], w[i]);
    for (int i = 0; i < SCP_FIFO_DEPTH; i++)
    begin
      apb(1'b0, SCP_DATA_ADDR, 32'h0);
      check("rx word", rdat, {24'h0, r[i]});
    end
    apb(1'b0, SCP_STAT_ADDR, 32'h0);
    check("rx drained", rdat[SCP_RNE_BIT], 1'b0);
    // Loopback ignores the peer's differing reply
    peer_u.rsp.delete();
    peer_u.rsp.push_back(8'h5A);
    apb(1'b1, SCP_CTRL1_ADDR, 32'h0);
    apb(1'b1, SCP_CTRL1_ADDR, 32'h3);
    apb(1'b1, SCP_DATA_ADDR, 32'h00C3);
    wait_stat(SCP_BSY_BIT, 1'b0);
    apb(1'b0, SCP_DATA_ADDR, 32'h0);
    check("loopback", rdat, 32'h00C3);
    // Slave role: mode bit taken only while off
    apb(1'b1, SCP_CTRL1_ADDR, 32'h0);
    apb(1'b1, SCP_CTRL1_ADDR, 32'h4);
    apb(1'b1, SCP_CTRL1_ADDR, 32'h6);
    apb(1'b0, SCP_CTRL1_ADDR, 32'h0);
    check("slave mode", rdat[3:0], 4'h6);
    seed = lfsr(seed);
    apb(1'b1, SCP_DATA_ADDR, {24'h0, seed[7:0]});
    #7 peer_u.xfer(seed[15:8]);
    check("slave tx", peer_u.mrx, seed[7:0]);
    wait_stat(SCP_RNE_BIT, 1'b1);
    apb(1'b0, SCP_DATA_ADDR, 32'h0);
    check("slave rx", rdat, {24'h0, seed[15:8]});
    // Reply line muted, but the frame still comes in
    apb(1'b1, SCP_CTRL1_ADDR, 32'hE);
    #7 peer_u.xfer(8'h96);
    wait_stat(SCP_RNE_BIT, 1'b1);
    apb(1'b0, SCP_DATA_ADDR, 32'h0);
    check("muted slave rx", rdat, 32'h0096);
    report_and_stop();
  end
endmodule : scp_ctrl_bench
`default_nettype wire
